/* File: clf_consts.svh */
/*
 constants of the character display command front end: prefix bytes, strap codes, timing.
 assumes a 10 MHz clock.
*/
`ifndef CLF_CONSTS_SVH
`define CLF_CONSTS_SVH
`define CLF_ESC_BYTE      8'h1B
`define CLF_BRACKET_BYTE  8'h5B
`define CLF_I2C_ADDR_FIXED 7'h48
`define CLF_CLK_HZ        10000000
`define CLF_BAUD_2400     2400
`define CLF_BAUD_4800     4800
`define CLF_BAUD_9600     9600
`define CLF_DIV(b)        (`CLF_CLK_HZ / (b))
`define CLF_MODE_U2400    3'h0
`define CLF_MODE_U4800    3'h1
`define CLF_MODE_U9600    3'h2
`define CLF_MODE_UNV      3'h3
`define CLF_MODE_I2C      3'h4
`define CLF_MODE_I2CNV    3'h5
`define CLF_MODE_SPI      3'h6
`define CLF_MODE_NV       3'h7
`define CLF_MAX_PARAMS    4
`endif

/* File: clf_pkg.sv */
/*
 types of the character display command front end.
 assumes clf_consts.svh for the numeric constants.
*/
package clf_pkg;
	typedef enum logic [1:0] {
		CLF_PORT_UART = 2'h0,
		CLF_PORT_I2C  = 2'h1,
		CLF_PORT_SPI  = 2'h2
	} clf_port_t;

	typedef struct packed {
		logic       is_cmd;
		logic [7:0] cmd;
		logic [7:0] p0;
		logic [7:0] p1;
		logic [7:0] p2;
		logic [7:0] p3;
		logic [2:0] nparam;
	} clf_item_t;
endpackage

/* File: clf_buf2.sv */
/*
 two-entry buffer with valid and ready on both sides.
 assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module clf_buf2 (
	input  wire logic               clk,
	input  wire logic               reset_n,
	input  wire logic               in_valid,
	output logic                    in_ready,
	input  wire clf_pkg::clf_item_t in_item,
	output logic                    out_valid,
	input  wire logic               out_ready,
	output clf_pkg::clf_item_t      out_item
);
	clf_pkg::clf_item_t mem_r [0:1];
	clf_pkg::clf_item_t mem_nxt [0:1];
	logic [1:0] cnt_r, cnt_nxt;
	logic       rd_r, rd_nxt;
	logic       wr_r, wr_nxt;
	logic       push, pop;

	always_comb begin
		push       = in_valid && (cnt_r != 2'h2);
		pop        = (cnt_r != 2'h0) && out_ready;
		mem_nxt[0] = mem_r[0];
		mem_nxt[1] = mem_r[1];
		if (push) begin
			mem_nxt[wr_r] = in_item;
		end
		wr_nxt  = push ? ~wr_r : wr_r;
		rd_nxt  = pop ? ~rd_r : rd_r;
		cnt_nxt = cnt_r + {1'b0, push} - {1'b0, pop};
		if (!reset_n) begin
			wr_nxt  = 1'b0;
			rd_nxt  = 1'b0;
			cnt_nxt = 2'h0;
		end
	end

	always_ff @(posedge clk) begin
		mem_r[0] <= mem_nxt[0];
		mem_r[1] <= mem_nxt[1];
		wr_r     <= wr_nxt;
		rd_r     <= rd_nxt;
		cnt_r    <= cnt_nxt;
	end

	assign in_ready  = (cnt_r != 2'h2);
	assign out_valid = (cnt_r != 2'h0);
	assign out_item  = mem_r[rd_r];
endmodule
`default_nettype wire

/* File: clf_front_end.sv */
/*
 host front end of a 16x2 character display: strap-selected uart, i2c target or spi receiver,
 escape sequence parser, two-entry output buffer.
 assumes pins asynchronous to clk; nonvolatile settings arrive as stable inputs.
*/
// Function
// R1: an instruction begins only with byte 1B immediately followed by byte 5B.
// R2: after the prefix, numeric parameters are collected and a command character ends the instruction.
// R3: exactly one of uart, i2c or spi is active, chosen by the straps.
// R4: on the earlier board revision a fitted jumper reads 1.
// R5: on the later board revision the polarity is inverted, a fitted jumper reads 0.
// R6: codes 000, 001, 010 select the uart at 2400, 4800 and 9600 baud.
// R7: code 011 selects the uart with its rate from stored settings.
// R8: code 100 selects the i2c target at address 48.
// R9: code 101 selects the i2c target at a stored address.
// R10: code 110 selects spi alone.
// R11: code 111 takes both protocol and parameter from stored settings.
// R12: straps are sampled once after reset and held until the next reset.
// R13: bytes outside an escape sequence are passed on as characters.
`include "clf_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module clf_front_end (
	input  wire logic               clk,
	input  wire logic               reset_n,
	input  wire logic               board_rev_late,
	input  wire logic               mode_strap_0,
	input  wire logic               mode_strap_1,
	input  wire logic               mode_strap_2,
	input  wire logic [1:0]         nv_port,
	input  wire logic [15:0]        nv_baud_div,
	input  wire logic [6:0]         nv_i2c_addr,
	input  wire logic               uart_rxd,
	output logic                    uart_txd,
	input  wire logic               scl_in,
	input  wire logic               sda_in,
	output logic                    sda_oe_n,
	input  wire logic               spi_ss_n,
	input  wire logic               spi_sck,
	input  wire logic               spi_mosi,
	output logic                    spi_miso,
	output logic                    item_valid,
	input  wire logic               item_ready,
	output clf_pkg::clf_item_t      item,
	output logic                    rx_overrun
);
	typedef enum logic [1:0] {
		CLF_P_TEXT = 2'h0,
		CLF_P_ESC  = 2'h1,
		CLF_P_ARGS = 2'h2
	} clf_pst_t;

	// two-flop synchronisers, first stage read only by the second
	logic [6:0] s1_r, s2_r, s3_r;
	logic       sel_done_r, sel_done_nxt;
	clf_pkg::clf_port_t port_r, port_nxt;
	logic [15:0] div_r, div_nxt;
	logic [6:0]  addr_r, addr_nxt;
	logic [2:0]  code;
	// uart
	logic [15:0] u_cnt_r, u_cnt_nxt;
	logic [3:0]  u_bit_r, u_bit_nxt;
	logic [7:0]  u_sh_r, u_sh_nxt;
	logic        u_busy_r, u_busy_nxt;
	// i2c and spi share one shift register, only one port runs
	logic [7:0]  sh_r, sh_nxt;
	logic [3:0]  nb_r, nb_nxt;
	logic        i_act_r, i_act_nxt, i_me_r, i_me_nxt, i_hdr_r, i_hdr_nxt;
	logic        ack_r, ack_nxt;
	// parser
	clf_pst_t    pst_r, pst_nxt;
	clf_pkg::clf_item_t acc_r, acc_nxt;
	logic        byte_vld;
	logic [7:0]  byte_val;
	logic        emit;
	clf_pkg::clf_item_t emit_item;
	logic        in_ready;
	logic        ovr_r, ovr_nxt;
	logic        bv_valid;
	clf_pkg::clf_item_t bv_item;
	logic        scl_rise, scl_fall, sda_rise, sda_fall, sck_rise;

	always_ff @(posedge clk) begin
		s1_r <= {spi_mosi, spi_sck, spi_ss_n, sda_in, scl_in, uart_rxd, 1'b0};
		s2_r <= s1_r;
		s3_r <= s2_r;
	end

	// straps: invert for the later revision
	always_comb begin
		code = {mode_strap_2, mode_strap_1, mode_strap_0} ^ {3{board_rev_late}}; // R4 R5
	end

	// strap capture after release, held until next reset
	always_comb begin
		sel_done_nxt = 1'b1; // R12
		port_nxt     = port_r;
		div_nxt      = div_r;
		addr_nxt     = addr_r;
		if (!sel_done_r) begin
			addr_nxt = `CLF_I2C_ADDR_FIXED;
			div_nxt  = 16'(`CLF_DIV(`CLF_BAUD_9600));
			case (code) // R3
				`CLF_MODE_U2400: begin port_nxt = clf_pkg::CLF_PORT_UART; div_nxt = 16'(`CLF_DIV(`CLF_BAUD_2400)); end // R6
				`CLF_MODE_U4800: begin port_nxt = clf_pkg::CLF_PORT_UART; div_nxt = 16'(`CLF_DIV(`CLF_BAUD_4800)); end // R6
				`CLF_MODE_U9600: port_nxt = clf_pkg::CLF_PORT_UART; // R6
				`CLF_MODE_UNV:   begin port_nxt = clf_pkg::CLF_PORT_UART; div_nxt = nv_baud_div; end // R7
				`CLF_MODE_I2C:   port_nxt = clf_pkg::CLF_PORT_I2C; // R8
				`CLF_MODE_I2CNV: begin port_nxt = clf_pkg::CLF_PORT_I2C; addr_nxt = nv_i2c_addr; end // R9
				`CLF_MODE_SPI:   port_nxt = clf_pkg::CLF_PORT_SPI; // R10
				default: begin // R11
					port_nxt = (nv_port == 2'h3) ? clf_pkg::CLF_PORT_UART : clf_pkg::clf_port_t'(nv_port);
					div_nxt  = nv_baud_div;
					addr_nxt = nv_i2c_addr;
				end
			endcase
		end
		if (!reset_n) begin
			sel_done_nxt = 1'b0;
			port_nxt     = clf_pkg::CLF_PORT_UART;
		end
	end

	always_ff @(posedge clk) begin
		sel_done_r <= sel_done_nxt;
		port_r     <= port_nxt;
		div_r      <= div_nxt;
		addr_r     <= addr_nxt;
	end

	// receivers
	always_comb begin
		scl_rise  = s2_r[2] && !s3_r[2];
		scl_fall  = !s2_r[2] && s3_r[2];
		sda_rise  = s2_r[3] && !s3_r[3];
		sda_fall  = !s2_r[3] && s3_r[3];
		sck_rise  = s2_r[5] && !s3_r[5];
		u_cnt_nxt = u_cnt_r;
		u_bit_nxt = u_bit_r;
		u_sh_nxt  = u_sh_r;
		u_busy_nxt = u_busy_r;
		sh_nxt    = sh_r;
		nb_nxt    = nb_r;
		i_act_nxt = i_act_r;
		i_me_nxt  = i_me_r;
		i_hdr_nxt = i_hdr_r;
		ack_nxt   = ack_r;
		byte_vld  = 1'b0;
		byte_val  = 8'h00;
		case (port_r) // R3
			clf_pkg::CLF_PORT_UART: begin
				if (!u_busy_r) begin
					if (!s2_r[1]) begin
						u_busy_nxt = 1'b1;
						u_bit_nxt  = 4'h0;
						u_cnt_nxt  = {1'b0, div_r[15:1]};
					end
				end else if (u_cnt_r != 16'h0000) begin
					u_cnt_nxt = u_cnt_r - 16'h0001;
				end else begin
					u_cnt_nxt = div_r - 16'h0001;
					u_bit_nxt = u_bit_r + 4'h1;
					if (u_bit_r == 4'h0 && s2_r[1]) begin
						u_busy_nxt = 1'b0;
					end else if (u_bit_r == 4'h9) begin
						u_busy_nxt = 1'b0;
						byte_vld   = s2_r[1];
						byte_val   = u_sh_r;
					end else if (u_bit_r != 4'h0) begin
						u_sh_nxt = {s2_r[1], u_sh_r[7:1]};
					end
				end
			end
			clf_pkg::CLF_PORT_I2C: begin
				if (s2_r[2] && sda_fall) begin
					i_act_nxt = 1'b1;
					i_hdr_nxt = 1'b1;
					nb_nxt    = 4'h0;
				end else if (s2_r[2] && sda_rise) begin
					i_act_nxt = 1'b0;
					i_me_nxt  = 1'b0;
					ack_nxt   = 1'b0;
				end else if (i_act_r && scl_rise && nb_r < 4'h8) begin
					sh_nxt = {sh_r[6:0], s2_r[3]};
					nb_nxt = nb_r + 4'h1;
				end else if (i_act_r && scl_fall) begin
					if (nb_r == 4'h8) begin
						if (i_hdr_r) begin
							i_me_nxt = (sh_r[7:1] == addr_r) && !sh_r[0];
							ack_nxt  = (sh_r[7:1] == addr_r) && !sh_r[0];
						end else begin
							ack_nxt  = i_me_r && in_ready;
							byte_vld = i_me_r && in_ready;
							byte_val = sh_r;
						end
						i_hdr_nxt = 1'b0;
						nb_nxt    = 4'h9;
					end else if (nb_r == 4'h9) begin
						ack_nxt = 1'b0;
						nb_nxt  = 4'h0;
					end
				end
			end
			default: begin
				if (s2_r[4]) begin
					nb_nxt = 4'h0;
				end else if (sck_rise) begin
					sh_nxt = {sh_r[6:0], s2_r[6]};
					if (nb_r == 4'h7) begin
						nb_nxt   = 4'h0;
						byte_vld = 1'b1;
						byte_val = {sh_r[6:0], s2_r[6]};
					end else begin
						nb_nxt = nb_r + 4'h1;
					end
				end
			end
		endcase
		if (!reset_n) begin
			u_busy_nxt = 1'b0;
			u_cnt_nxt  = 16'h0000;
			u_bit_nxt  = 4'h0;
			nb_nxt     = 4'h0;
			i_act_nxt  = 1'b0;
			i_me_nxt   = 1'b0;
			i_hdr_nxt  = 1'b0;
			ack_nxt    = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		u_cnt_r  <= u_cnt_nxt;
		u_bit_r  <= u_bit_nxt;
		u_sh_r   <= u_sh_nxt;
		u_busy_r <= u_busy_nxt;
		sh_r     <= sh_nxt;
		nb_r     <= nb_nxt;
		i_act_r  <= i_act_nxt;
		i_me_r   <= i_me_nxt;
		i_hdr_r  <= i_hdr_nxt;
		ack_r    <= ack_nxt;
	end

	// escape parser; parameters are decimal digits separated by ';'
	always_comb begin
		pst_nxt   = pst_r;
		acc_nxt   = acc_r;
		emit      = 1'b0;
		emit_item = '0;
		ovr_nxt   = ovr_r;
		if (byte_vld) begin
			if (!in_ready) begin
				ovr_nxt = 1'b1;
			end else begin
				case (pst_r)
					CLF_P_TEXT: begin
						if (byte_val == `CLF_ESC_BYTE) begin
							pst_nxt = CLF_P_ESC; // R1
						end else begin
							emit          = 1'b1; // R13
							emit_item.cmd = byte_val;
						end
					end
					CLF_P_ESC: begin
						if (byte_val == `CLF_BRACKET_BYTE) begin
							pst_nxt = CLF_P_ARGS; // R1
							acc_nxt = '0;
						end else begin
							// lone escape without bracket is dropped, the byte is shown unless it is another escape, which starts a new sequence
							pst_nxt       = CLF_P_TEXT; // R1
							emit          = (byte_val != `CLF_ESC_BYTE);
							emit_item.cmd = byte_val;
							pst_nxt       = (byte_val == `CLF_ESC_BYTE) ? CLF_P_ESC : CLF_P_TEXT;
						end
					end
					CLF_P_ARGS: begin
						if (byte_val >= 8'h30 && byte_val <= 8'h39) begin
							acc_nxt.p0 = 8'(acc_r.p0 * 8'h0A + (byte_val - 8'h30)); // R2
							if (acc_r.nparam == 3'h0) begin
								acc_nxt.nparam = 3'h1;
							end
						end else if (byte_val == 8'h3B) begin
							if (acc_r.nparam < 3'(`CLF_MAX_PARAMS)) begin
								acc_nxt.p3 = acc_r.p2;
								acc_nxt.p2 = acc_r.p1;
								acc_nxt.p1 = acc_r.p0;
								acc_nxt.p0 = 8'h00;
								acc_nxt.nparam = acc_r.nparam + 3'h1;
							end
						end else begin
							emit           = 1'b1; // R2
							emit_item      = acc_r;
							emit_item.is_cmd = 1'b1;
							emit_item.cmd  = byte_val;
							pst_nxt        = CLF_P_TEXT;
						end
					end
					default: pst_nxt = CLF_P_TEXT;
				endcase
			end
		end
		if (!reset_n) begin
			pst_nxt = CLF_P_TEXT;
			acc_nxt = '0;
			ovr_nxt = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		pst_r <= pst_nxt;
		acc_r <= acc_nxt;
		ovr_r <= ovr_nxt;
	end

	clf_buf2 u_buf (
		.clk       (clk),
		.reset_n   (reset_n),
		.in_valid  (emit),
		.in_ready  (in_ready),
		.in_item   (emit_item),
		.out_valid (bv_valid),
		.out_ready (item_ready),
		.out_item  (bv_item)
	);

	always_ff @(posedge clk) begin
		uart_txd   <= 1'b1;
		sda_oe_n   <= !(reset_n && ack_nxt);
		spi_miso   <= 1'b0;
		rx_overrun <= ovr_nxt;
	end

	assign item_valid = bv_valid;
	assign item       = bv_item;
endmodule
`default_nettype wire

/* File: clf_front_end_sva.sv */
/*
 port checker of clf_front_end.
 bound to every instance of the front end; sees its ports only.
*/
`timescale 1ns/1ps
`default_nettype none
module clf_front_end_sva (
	input wire logic               clk,
	input wire logic               reset_n,
	input wire logic               uart_txd,
	input wire logic               sda_oe_n,
	input wire logic               spi_miso,
	input wire logic               item_valid,
	input wire logic               item_ready,
	input wire clf_pkg::clf_item_t item,
	input wire logic               rx_overrun
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	sequence s_stall;
		item_valid && !item_ready;
	endsequence
	sequence s_cmd;
		item_valid && item.is_cmd;
	endsequence
	a_item_holds: assert property (s_stall |=> item_valid && $stable(item))
		else $error("item changed while stalled");
	a_reset_clear: assert property ($rose(reset_n) |-> !item_valid && sda_oe_n && !rx_overrun)
		else $error("outputs not idle after reset");
	a_overrun_sticky: assert property (rx_overrun |=> rx_overrun)
		else $error("overrun flag dropped");
	a_txd_idle: assert property (uart_txd)
		else $error("uart output left idle level");
	a_miso_low: assert property (!spi_miso)
		else $error("spi output not low");
	a_no_escape_char: assert property (item_valid && !item.is_cmd |-> item.cmd != 8'h1B)
		else $error("escape byte shown as character");
	a_param_count: assert property (s_cmd |-> item.nparam <= 3'h4)
		else $error("too many parameters");
	a_cmd_final: assert property (s_cmd |-> !(item.cmd inside {[8'h30:8'h39], 8'h3B}))
		else $error("parameter byte ended a command");
endmodule
bind clf_front_end clf_front_end_sva i_clf_front_end_sva (.clk(clk), .reset_n(reset_n),
	.uart_txd(uart_txd), .sda_oe_n(sda_oe_n), .spi_miso(spi_miso), .item_valid(item_valid),
	.item_ready(item_ready), .item(item), .rx_overrun(rx_overrun));
`default_nettype wire

/* File: clf_host_model.sv */
/*
 host model: spi master (mode 0, msb first) and uart sender (8N1, lsb first).
 tasks are called from the bench at falling clock edges.
*/
`timescale 1ns/1ps
`default_nettype none
module clf_host_model (
	input wire logic clk,
	output logic     ss_n,
	output logic     sck,
	output logic     mosi,
	output logic     rxd,
	output logic     scl,
	output logic     sda,
	input wire logic ack_n
);
	initial begin
		scl = 1'b1;
		sda = 1'b1;
		ss_n = 1'b1;
		sck = 1'b0;
		mosi = 1'b0;
		rxd = 1'b1;
	end
	task automatic spi_byte(input logic [7:0] b);
		ss_n = 1'b0;
		for (int i = 7; i >= 0; i--) begin
			mosi = b[i];
			repeat (4) @(negedge clk);
			sck = 1'b1;
			repeat (4) @(negedge clk);
			sck = 1'b0;
		end
		ss_n = 1'b1;
		// released line must not keep showing the last bit
		mosi = ~mosi;
		// a gap with select high, so the next byte never meets a zero-width deselect
		repeat (2) @(negedge clk);
	endtask
	// data changes only while scl is low, so no false start or stop is seen
	task automatic i2c_bit(input logic v);
		scl = 1'b0;
		repeat (2) @(negedge clk);
		sda = v;
		repeat (2) @(negedge clk);
		scl = 1'b1;
		repeat (4) @(negedge clk);
	endtask
	task automatic i2c_byte(input logic [7:0] x, output logic ack);
		for (int i = 7; i >= 0; i--) i2c_bit(x[i]);
		scl = 1'b0;
		repeat (2) @(negedge clk);
		sda = 1'b1;
		repeat (2) @(negedge clk);
		scl = 1'b1;
		repeat (2) @(negedge clk);
		ack = !ack_n;
		repeat (2) @(negedge clk);
	endtask
	task automatic i2c_write(input logic [6:0] a, input logic [7:0] d, output logic ok);
		logic dack;
		sda = 1'b0;
		repeat (4) @(negedge clk);
		i2c_byte({a, 1'b0}, ok);
		i2c_byte(d, dack);
		scl = 1'b0;
		repeat (2) @(negedge clk);
		sda = 1'b0;
		repeat (2) @(negedge clk);
		scl = 1'b1;
		repeat (4) @(negedge clk);
		sda = 1'b1;
		repeat (4) @(negedge clk);
	endtask
	task automatic uart_byte(input logic [7:0] b, input int div);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			rxd = f[i];
			repeat (div) @(negedge clk);
		end
	endtask
endmodule
`default_nettype wire

/* File: clf_front_end_tb.sv */
/*
 self-checking bench of clf_front_end.
 assumes clf_host_model drives the host pins; i2c pins rest idle until the i2c tests at the end.
*/
`timescale 1ns/1ps
`default_nettype none
module clf_front_end_tb;
	logic               clk, reset_n, rev, hold, uart, ready, valid, ovr, scl, sda;
	logic               ss_n, sck, mosi, rxd, ack_n, ok;
	logic [2:0]         strap;
	logic [15:0]        div;
	logic [1:0]         nvp;
	logic [6:0]         addr;
	logic [7:0]         b;
	clf_pkg::clf_item_t itm;
	clf_pkg::clf_item_t exp_q[$];
	clf_pkg::clf_item_t got_q[$];
	int                 n_errors, n_checks;

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	clf_host_model i_clf_host_model (.clk(clk), .ss_n(ss_n), .sck(sck), .mosi(mosi), .rxd(rxd),
		.scl(scl), .sda(sda), .ack_n(ack_n));
	clf_front_end i_clf_front_end (.clk(clk), .reset_n(reset_n), .board_rev_late(rev),
		.mode_strap_0(strap[0]), .mode_strap_1(strap[1]), .mode_strap_2(strap[2]), .nv_port(nvp),
		.nv_baud_div(div), .nv_i2c_addr(addr), .uart_rxd(rxd), .uart_txd(), .scl_in(scl),
		.sda_in(sda), .sda_oe_n(ack_n), .spi_ss_n(ss_n), .spi_sck(sck), .spi_mosi(mosi), .spi_miso(),
		.item_valid(valid), .item_ready(ready), .item(itm), .rx_overrun(ovr));

	always @(negedge clk) ready <= hold ? 1'b0 : 1'($urandom % 2);
	always @(posedge clk) if (reset_n && valid === 1'b1 && ready) got_q.push_back(itm);

	function automatic clf_pkg::clf_item_t mk(logic c, logic [7:0] k, logic [7:0] p, logic [7:0] q,
		logic [2:0] n);
		mk = '0;
		mk.is_cmd = c;
		mk.cmd = k;
		mk.p0 = p;
		mk.p1 = q;
		mk.nparam = n;
	endfunction
	// only fields that carry meaning for the item kind are compared
	function automatic logic [27:0] key(clf_pkg::clf_item_t t);
		key = {t.is_cmd, t.cmd, t.is_cmd ? t.p0 : 8'h00, (t.is_cmd && t.nparam > 1) ? t.p1 : 8'h00,
			t.is_cmd ? t.nparam : 3'h0};
	endfunction
	task finish_test;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task check(string what, logic [31:0] e, logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			n_errors++;
			$display("Error %s expected %h seen %h", what, e, g);
		end
	endtask
	task reset_dut(logic r, logic [2:0] code);
		rev = r;
		strap = r ? ~code : code;
		reset_n = 1'b0;
		repeat (2) @(negedge clk);
		reset_n = 1'b1;
		repeat (4) @(negedge clk);
		exp_q.delete();
		got_q.delete();
	endtask
	task send(logic [7:0] x);
		if (uart)
			i_clf_host_model.uart_byte(x, div);
		else
			i_clf_host_model.spi_byte(x);
	endtask
	task send_str(string s);
		foreach (s[i]) send(s[i]);
	endtask
	task drain(string name);
		int t;
		hold = 1'b0;
		t = 0;
		while (got_q.size() < exp_q.size() && t < 2000) begin
			@(negedge clk);
			t++;
		end
		if (t == 2000) begin
			n_errors++;
			finish_test();
		end
		repeat (20) @(negedge clk);
		check({name, " count"}, exp_q.size(), got_q.size());
		foreach (exp_q[i]) if (i < got_q.size()) check(name, key(exp_q[i]), key(got_q[i]));
		$display("test %s done", name);
		exp_q.delete();
		got_q.delete();
	endtask

	initial begin
		void'($urandom(32'h66A5));
		{reset_n, rev, hold, uart, strap} = '0;
		div = 16'h0010;
		nvp = 2'h0;
		addr = 7'h11;
		reset_dut(1'b0, 3'h6);
		// straps moved after sampling must not change the port
		strap = 3'h0;
		repeat (6) begin
			b = 8'h20 + 8'($urandom % 95);
			send(b);
			exp_q.push_back(mk(1'b0, b, 0, 0, 0));
		end
		drain("spi chars");
		send(8'h1B);
		send_str("[12;3H");
		exp_q.push_back(mk(1'b1, "H", 8'd3, 8'd12, 3'h2));
		send(8'h1B);
		send(8'h1B);
		send_str("[7m");
		exp_q.push_back(mk(1'b1, "m", 8'd7, 0, 3'h1));
		send(8'h1B);
		send("x");
		exp_q.push_back(mk(1'b0, "x", 0, 0, 0));
		drain("escape");
		hold = 1'b1;
		repeat (3) begin
			b = 8'h20 + 8'($urandom % 95);
			send(b);
			if (exp_q.size() < 2) exp_q.push_back(mk(1'b0, b, 0, 0, 0));
		end
		repeat (5) @(negedge clk);
		check("overrun", 1, ovr);
		drain("overrun");
		uart = 1'b1;
		reset_dut(1'b1, 3'h3);
		check("overrun clear", 0, ovr);
		send("A");
		exp_q.push_back(mk(1'b0, "A", 0, 0, 0));
		send(8'h1B);
		send_str("[5;6;7j");
		exp_q.push_back(mk(1'b1, "j", 8'd7, 8'd6, 3'h3));
		drain("uart stored rate");
		i_clf_host_model.spi_byte(8'h41);
		drain("idle port ignored");
		div = 16'd1041;
		reset_dut(1'b0, 3'h2);
		send("u");
		exp_q.push_back(mk(1'b1 == 1'b0, "u", 0, 0, 0));
		drain("uart 9600");
		uart = 1'b0;
		nvp = 2'h2;
		reset_dut(1'b0, 3'h7);
		send("Z");
		exp_q.push_back(mk(1'b0, "Z", 0, 0, 0));
		drain("stored protocol");
		reset_dut(1'b0, 3'h4);
		i_clf_host_model.i2c_write(7'h48, "K", ok);
		check("i2c fixed ack", 1, ok);
		exp_q.push_back(mk(1'b0, "K", 0, 0, 0));
		drain("i2c fixed");
		reset_dut(1'b0, 3'h5);
		i_clf_host_model.i2c_write(7'h48, "M", ok);
		check("i2c wrong addr", 0, ok);
		i_clf_host_model.i2c_write(7'h11, "L", ok);
		check("i2c stored ack", 1, ok);
		exp_q.push_back(mk(1'b0, "L", 0, 0, 0));
		drain("i2c stored");
		finish_test();
	end
endmodule
`default_nettype wire
